// ===== logic/cos_pkg.sv
// Constants and carrier types for the clock output select and strap block.
// Assumes a 250 MHz system clock from which the processor, bus and USB rates are synthesised.
package cos_pkg;

  // ==========================================================================
  // Clock rates
  localparam int ACC_W = 24;
  localparam longint SYS_KHZ = 250000;
  localparam longint CPU_FAST_KHZ = 100000;
  localparam longint CPU_SLOW_KHZ = 66800;
  localparam longint USB_KHZ = 48000;
  localparam longint REF_KHZ = 14318;

  // ==========================================================================
  // Output grouping and bus divisors
  localparam int NUM_CPU = 2;
  localparam int NUM_BUS = 7;
  localparam int BUS_CNT_W = 2;
  localparam logic [BUS_CNT_W-1:0] BUS_DIV_FAST = 2'h3;
  localparam logic [BUS_CNT_W-1:0] BUS_DIV_SLOW = 2'h2;

  // ==========================================================================
  // Strap sampling window, counted in reference edges and rounded up
  localparam longint SAMPLE_TIME_US = 2000;
  localparam int SAMPLE_EDGES = int'((SAMPLE_TIME_US * REF_KHZ + 64'd999) / 64'd1000);

  // ==========================================================================
  // Phase increment for an average output rate given in kHz.
  function automatic logic [ACC_W-1:0] inc_of(input longint khz);
    return ACC_W'((khz * (64'd1 << ACC_W)) / SYS_KHZ);
  endfunction

  localparam logic [ACC_W-1:0] INC_CPU_FAST = inc_of(CPU_FAST_KHZ);
  localparam logic [ACC_W-1:0] INC_CPU_SLOW = inc_of(CPU_SLOW_KHZ);
  localparam logic [ACC_W-1:0] INC_USB = inc_of(USB_KHZ);

  typedef struct packed {
    logic [NUM_CPU-1:0] processor_clock_outs;
    logic [NUM_BUS-1:0] bus_clock_outs;
    logic irq_ctrl_clock_out;
    logic usb_clock_out;
    logic selectable_usb_clock_out;
  } cos_clk_outs_t;

endpackage

// ===== logic/cos_nco.sv
// Phase accumulator that synthesises one clock from the system clock.
// Assumes the increment is below half the accumulator range.
`timescale 1ns/1ns
module cos_nco #(
  parameter int ACC_W = 24
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [ACC_W-1:0] inc_i,
  output logic clk_o,
  output logic rise_o
);

  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic clk_ff;
  logic rise_ff;

  assign nxt_acc = acc_ff + inc_i;

  // ==========================================================================
  // Accumulator
  // The output edge lands on a system clock edge, so it carries up to one
  // system period of jitter; the average rate is exact to the increment.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc_ff <= '0;
      clk_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else if (ce_i) begin
      acc_ff <= nxt_acc;
      clk_ff <= nxt_acc[ACC_W-1];
      rise_ff <= nxt_acc[ACC_W-1] & ~clk_ff;
    end
  end

  assign clk_o = clk_ff;
  assign rise_o = rise_ff;

endmodule

// ===== logic/cos_top.sv
// Output rate selection and power-up strap latching of a system clock generator.
// Assumes reset_i is the power-on reset, held until the supply has come up.
`timescale 1ns/1ns

module cos_top #(
  parameter int SAMPLE_EDGES = cos_pkg::SAMPLE_EDGES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic cpu_speed_select_i,
  input wire logic ref_xtal_in_i,
  input wire logic strap_ref_dual_pin_i,
  output logic strap_ref_dual_pin_o,
  output logic strap_ref_dual_pin_oe_o,
  output logic usb_rate_strap_o,
  output logic sample_done_o,
  output cos_pkg::cos_clk_outs_t clk_outs_o
);

  localparam int CNT_W = $clog2(SAMPLE_EDGES + 1);
  localparam logic [CNT_W-1:0] LAST_EDGE = CNT_W'(SAMPLE_EDGES - 1);

  logic spd_meta_ff;
  logic spd_sync_ff;
  logic ref_meta_ff;
  logic ref_sync_ff;
  logic ref_prev_ff;
  logic strap_meta_ff;
  logic strap_sync_ff;
  logic [CNT_W-1:0] sample_cnt_ff;
  logic sample_done_ff;
  logic strap_latched_ff;
  logic ref_copy_ff;
  logic irq_ff;
  logic [cos_pkg::BUS_CNT_W-1:0] bus_cnt_ff;
  logic [cos_pkg::BUS_CNT_W-1:0] bus_div;
  logic bus_ff;
  logic half_ff;
  logic usb_sel_ff;
  logic ref_rise;
  logic [cos_pkg::ACC_W-1:0] cpu_inc;
  logic cpu_clk;
  logic cpu_rise;
  logic usb_clk;
  logic usb_rise;

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      spd_meta_ff <= 1'b0;
      spd_sync_ff <= 1'b0;
      ref_meta_ff <= 1'b0;
      ref_sync_ff <= 1'b0;
      ref_prev_ff <= 1'b0;
      strap_meta_ff <= 1'b0;
      strap_sync_ff <= 1'b0;
    end else if (ce_i) begin
      spd_meta_ff <= cpu_speed_select_i;
      spd_sync_ff <= spd_meta_ff;
      ref_meta_ff <= ref_xtal_in_i;
      ref_sync_ff <= ref_meta_ff;
      ref_prev_ff <= ref_sync_ff;
      strap_meta_ff <= strap_ref_dual_pin_i;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  assign ref_rise = ref_sync_ff & ~ref_prev_ff;

  // ==========================================================================
  // Strap sampling window
  // Nothing but power-on reset clears the latch; the window runs only once.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sample_cnt_ff <= '0;
      sample_done_ff <= 1'b0;
      strap_latched_ff <= 1'b0;
    end else if (ce_i && !sample_done_ff && ref_rise) begin
      if (sample_cnt_ff == LAST_EDGE) begin
        sample_done_ff <= 1'b1;
        strap_latched_ff <= strap_sync_ff;
      end else begin
        sample_cnt_ff <= sample_cnt_ff + CNT_W'(1);
      end
    end
  end

  // ==========================================================================
  // Reference copies
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ref_copy_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce_i) begin
      ref_copy_ff <= ref_sync_ff & sample_done_ff;
      irq_ff <= ref_sync_ff;
    end
  end

  // The driver is enabled only once the strap has been latched.
  assign strap_ref_dual_pin_oe_o = sample_done_ff;
  assign strap_ref_dual_pin_o = ref_copy_ff;

  // ==========================================================================
  // Processor and bus clocks
  assign cpu_inc = spd_sync_ff ? cos_pkg::INC_CPU_FAST : cos_pkg::INC_CPU_SLOW;
  assign bus_div = spd_sync_ff ? cos_pkg::BUS_DIV_FAST : cos_pkg::BUS_DIV_SLOW;

  cos_nco #(.ACC_W(cos_pkg::ACC_W)) u_cpu_nco (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .inc_i(cpu_inc),
    .clk_o(cpu_clk),
    .rise_o(cpu_rise)
  );

  // The bus clock steps only on processor rising edges, so it always trails
  // the processor clock by one system cycle and never drifts from it.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bus_cnt_ff <= '0;
      bus_ff <= 1'b0;
    end else if (ce_i && cpu_rise) begin
      if (bus_cnt_ff >= bus_div - cos_pkg::BUS_CNT_W'(1)) begin
        bus_cnt_ff <= '0;
        bus_ff <= 1'b1;
      end else begin
        bus_cnt_ff <= bus_cnt_ff + cos_pkg::BUS_CNT_W'(1);
        bus_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // USB clocks
  cos_nco #(.ACC_W(cos_pkg::ACC_W)) u_usb_nco (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .inc_i(cos_pkg::INC_USB),
    .clk_o(usb_clk),
    .rise_o(usb_rise)
  );

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      half_ff <= 1'b0;
      usb_sel_ff <= 1'b0;
    end else if (ce_i) begin
      if (usb_rise) begin
        half_ff <= ~half_ff;
      end
      usb_sel_ff <= strap_latched_ff ? half_ff : usb_clk;
    end
  end

  // ==========================================================================
  // Outputs
  assign usb_rate_strap_o = strap_latched_ff;
  assign sample_done_o = sample_done_ff;
  // One assignment drives the whole struct, so the port has a single driver.
  assign clk_outs_o = '{
    processor_clock_outs: {cos_pkg::NUM_CPU{cpu_clk}},
    bus_clock_outs: {cos_pkg::NUM_BUS{bus_ff}},
    irq_ctrl_clock_out: irq_ff,
    usb_clock_out: usb_clk,
    selectable_usb_clock_out: usb_sel_ff
  };

  // ==========================================================================
  // Checks
  // The spacing is checked looking back, so a later speed change cannot spoil it.
  a_cpu_rate_fast: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (cpu_rise && $past(spd_sync_ff, 1) && $past(spd_sync_ff, 2) && $past(spd_sync_ff, 3)
     && $past(spd_sync_ff, 4) && !$past(reset_i, 4))
    |-> !$past(cpu_rise, 1) && ($past(cpu_rise, 2) || $past(cpu_rise, 3)))
    else $error("processor clock spacing wrong at fast rate");

  a_cpu_rate_slow: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    (cpu_rise && !$past(spd_sync_ff, 1) && !$past(spd_sync_ff, 2) && !$past(spd_sync_ff, 3)
     && !$past(spd_sync_ff, 4) && !$past(spd_sync_ff, 5) && !$past(reset_i, 5))
    |-> !$past(cpu_rise, 1) && !$past(cpu_rise, 2)
        && ($past(cpu_rise, 3) || $past(cpu_rise, 4)))
    else $error("processor clock spacing wrong at slow rate");

  a_bus_follows_cpu: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    $rose(bus_ff) |-> $past(cpu_rise) && $past(cpu_clk))
    else $error("bus clock rose away from a processor edge");

  a_strap_latch_value: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    $rose(sample_done_ff) |-> strap_latched_ff == $past(strap_sync_ff))
    else $error("strap latched a wrong level");

  a_sel_usb_half: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    ($rose(usb_sel_ff) && strap_latched_ff && $past(strap_latched_ff, 14))
    |-> usb_sel_ff[*5] ##[1:2] !usb_sel_ff[*4])
    else $error("selectable usb clock not at half rate");

  a_ref_copy_out: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    sample_done_ff |=> strap_ref_dual_pin_oe_o && strap_ref_dual_pin_o == $past(ref_sync_ff))
    else $error("reference copy not on the dual pin");

  a_irq_ref_copy: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    1'b1 |=> irq_ff == $past(ref_sync_ff))
    else $error("interrupt controller clock not following reference");

  a_usb_fixed_rate: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    usb_rise |-> ##1 !usb_rise[*4] ##[1:2] usb_rise)
    else $error("usb clock spacing wrong");

  a_pin_released: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !sample_done_ff |-> !strap_ref_dual_pin_oe_o && !strap_ref_dual_pin_o)
    else $error("dual pin driven during sampling window");

  a_strap_held: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    sample_done_ff |=> sample_done_ff && $stable(strap_latched_ff))
    else $error("latched strap changed after the window");

  a_done_on_count: assert property (@(posedge ref_clk_i) disable iff (reset_i || !ce_i)
    $rose(sample_done_ff) |-> $past(sample_cnt_ff) == LAST_EDGE && $past(ref_rise))
    else $error("window ended off terminal count");

endmodule

// ===== tb/cos_far_side.sv
// Far side of the block: the reference crystal and the strap resistor on the dual pin.
// Assumes the bench resolves nothing else on the pin; the device enable wins over the strap.
`timescale 1ns/1ns
module cos_far_side (
  input wire logic strap_level_i,
  input wire logic pin_drive_i,
  input wire logic pin_oe_i,
  output logic ref_xtal_o,
  output logic pin_level_o
);
  // ==========================================================================
  // Reference source
  // The crystal runs free; 70 ns is the nearest whole-ns period to the nominal rate.
  initial begin
    ref_xtal_o = 1'b0;
    #3;
    forever #35 ref_xtal_o = ~ref_xtal_o;
  end

  // ==========================================================================
  // Dual pin
  // The 10k strap only sets the level while the device leaves its buffer off.
  assign pin_level_o = pin_oe_i ? pin_drive_i : strap_level_i;
endmodule

// ===== tb/clock_output_select_strap_test.sv
// Self-checking bench for the clock output select and strap block.
// Assumes cos_far_side supplies the reference and the strap; window shortened to 8 edges.
`timescale 1ns/1ns
module clock_output_select_strap_test;
  localparam int EDGES = 8;
  logic ref_clk, reset, ce, speed, strap, ref_x, pin_lvl, pin_o, pin_oe, usb_strap, done;
  cos_pkg::cos_clk_outs_t outs;
  int fails = 0;
  int checked = 0;
  int cnt[7];
  int skew;

  cos_top #(.SAMPLE_EDGES(EDGES)) cos_top_i (.ref_clk_i(ref_clk), .reset_i(reset), .ce_i(ce),
    .cpu_speed_select_i(speed), .ref_xtal_in_i(ref_x), .strap_ref_dual_pin_i(pin_lvl),
    .strap_ref_dual_pin_o(pin_o), .strap_ref_dual_pin_oe_o(pin_oe),
    .usb_rate_strap_o(usb_strap), .sample_done_o(done), .clk_outs_o(outs));
  cos_far_side cos_far_side_i (.strap_level_i(strap), .pin_drive_i(pin_o),
    .pin_oe_i(pin_oe), .ref_xtal_o(ref_x), .pin_level_o(pin_lvl));

  // ==========================================================================
  // Clock and shared tasks
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol);
    checked++;
    if ($isunknown(g) || !(g + tol >= e && g <= e + tol)) begin
      fails++;
      $display("FAIL at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  // Counts rising edges of each watched clock over n system cycles.
  task automatic measure(input int n);
    logic [6:0] w, p;
    p = 7'h00;
    cnt = '{default: 0};
    skew = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      w = {ref_x, pin_lvl, outs.irq_ctrl_clock_out, outs.selectable_usb_clock_out,
           outs.usb_clock_out, outs.bus_clock_outs[0], outs.processor_clock_outs[0]};
      for (int k = 0; k < 7; k++) if (w[k] && !p[k]) cnt[k]++;
      if (outs.bus_clock_outs !== {7{outs.bus_clock_outs[0]}} ||
          outs.processor_clock_outs !== {2{outs.processor_clock_outs[0]}}) skew++;
      p = w;
    end
  endtask

  // Power cycle with a given strap level, then wait out the sampling window.
  task automatic power_up(input logic lvl);
    int n, refs, early;
    logic pr;
    strap = lvl;
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 reset = 1'b0;
    n = 0;
    refs = 0;
    early = 0;
    pr = ref_x;
    while (done !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      if (ref_x && !pr) refs++;
      pr = ref_x;
      if (pin_oe !== 1'b0 && done !== 1'b1) early++;
      n++;
    end
    chk(done, 1'b1, 0);
    chk(early, 0, 0);
    chk(refs >= EDGES, 1'b1, 0);
    chk(pin_oe, 1'b1, 0);
    chk(usb_strap, lvl, 0);
    strap = ~lvl;
  endtask

  // Checks every output rate over 8 us against the selected speed and strap.
  task automatic check_rates(input logic fast, input logic lvl);
    int ce_x, bdiv;
    ce_x = fast ? int'(cos_pkg::CPU_FAST_KHZ * 8 / 1000) : int'(cos_pkg::CPU_SLOW_KHZ * 8 / 1000);
    bdiv = fast ? int'(cos_pkg::BUS_DIV_FAST) : int'(cos_pkg::BUS_DIV_SLOW);
    measure(2000);
    chk(cnt[0], ce_x, 2);
    chk(cnt[1], ce_x / bdiv, 2);
    chk(skew, 0, 0);
    chk(cnt[2], int'(cos_pkg::USB_KHZ * 8 / 1000), 2);
    chk(cnt[3], int'(cos_pkg::USB_KHZ * 8 / 1000) / (lvl ? 2 : 1), 2);
    chk(cnt[4], cnt[6], 1);
    chk(cnt[5], cnt[6], 1);
    chk(usb_strap, lvl, 0);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_fast_strap_low;
    speed = 1'b1;
    power_up(1'b0);
    check_rates(1'b1, 1'b0);
    $display("test fast_strap_low done");
  endtask

  task automatic test_slow_strap_high_then_fast;
    speed = 1'b0;
    power_up(1'b1);
    check_rates(1'b0, 1'b1);
    speed = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check_rates(1'b1, 1'b1);
    $display("test slow_strap_high_then_fast done");
  endtask

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    speed = 1'b1;
    strap = 1'b0;
    @(posedge ref_clk);
    #1;
    test_fast_strap_low();
    test_slow_strap_high_then_fast();
    finish_test();
  end

  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
